// [hdl/wit_top.sv]
// watch interval timer with an axi4-lite register slave
//
// Overview of operation
// - 8-bit mode register, read/write, reset zero
// - bit 7 picks main clock /2^7 or /2^11
// - bits 6..4 pick interval 2^4..2^9; 6,7 prohibited
// - bit 3: flag every 2^14 or 2^5 periods
// - bit 1 runs 5-bit counter; zero clears it
// - bit 0 enables; zero clears prescaler and counter
// - watch counting only with bits 0 and 1 set
// - clearing bit 1 restarts counter, prescaler keeps running
// - normal mode fast clock gives periodic watch interrupt
// - interval interrupt repeats, concurrent with watch operation
//
// structure
// - a free-running divider stands in for the count clock source
// - divider low 7 bits all ones gives the fast watch tick
// - all 11 divider bits ones gives the slow watch tick
// - a tick is one aclk wide, so nothing here runs on a derived clock
// - the prescaler counts ticks only while the enable bit is set
// - the 5-bit counter counts only while enable and run are both set
//
// interval events
// - one event per 2^(4+code) ticks, taken from the prescaler low bits
// - codes 6 and 7 are refused: they raise no interval events at all
// - changing the code while running may give one short first interval
// - the prescaler is not cleared by a code change, by design
//
// watch events
// - normal mode: counter steps once per prescaler wrap, 2^14 ticks total
// - fast-feed mode: counter steps once per tick, 2^5 ticks total
// - event fires on the step that takes the counter from 31 back to 0
// - clearing only the run bit restarts the counter with the prescaler live
// - so the first watch event after such a restart may come early
//
// event reporting
// - every event sets a sticky status bit and gives a one-cycle pulse
// - status bits clear by writing a one; a new event wins over the clear
// - mask bits of the same layout gate status onto the level irq
// - irq follows status and mask with the same edge, no extra lag
// - pulse outputs appear at the same edge as the status bit
//
// register bus
// - axi4-lite slave, one write and one read at a time
// - write address and data are caught in either order
// - the write lands one edge after both are held, with bvalid
// - only byte lane 0 carries register data; lane 0 strobe low is a no-op
// - unmapped addresses answer slverr; writes there change nothing
// - reads answer at the same edge that takes the address
// - arready stays low from taking a read until its data is retired
// - unmapped reads return zero data
//
// limitations
// - the divider is cleared only by reset, so the tick phase is not aligned to mode writes
// - slow clock select makes one tick every 2048 aclk cycles
// - normal mode watch periods are long; tests favour fast-feed mode
// - mode bit 2 is not stored and always reads zero
//
// reset
// - synchronous and active low; every register returns to zero
// - awready and wready come up high as soon as reset is seen
// - arready rises at the first edge after reset is released
//
// outputs
// - every output is a flip-flop or the inverse of one held flag
// - pulse outputs never stand longer than one cycle
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module wit_top
    import wit_pkg::*;
#(
    parameter int ADDR_WIDTH = 22
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt and event outputs
    output logic irq,
    output logic watch_interrupt_request,
    output logic interval_interrupt_request
);
    // register state
    logic [7:0] watch_mode_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic irq_reg;
    logic watch_pulse_reg;
    logic ivl_pulse_reg;

    // axi write side state
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_WIDTH-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    // axi read side state
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    // mode fields
    wire clk_sel = watch_mode_reg[WIT_CLK_SEL_BIT];
    wire [2:0] ivl_code = watch_mode_reg[WIT_IVL_LSB +: 3];
    wire fast_mode = watch_mode_reg[WIT_FAST_BIT];
    wire run_ctl = watch_mode_reg[WIT_RUN_BIT];
    wire op_en = watch_mode_reg[WIT_EN_BIT];

    // free-running main clock divider; aclk stands for the main system clock
    wire [WIT_DIV_SLOW_EXP-1:0] div_count;
    wit_counter #(.WIDTH(WIT_DIV_SLOW_EXP)) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(1'b0),
        .inc(1'b1),
        .count(div_count)
    );
    // watch clock tick, one aclk wide
    wire tick_fast = &div_count[WIT_DIV_FAST_EXP-1:0];
    wire tick_slow = &div_count;
    wire watch_tick = clk_sel ? tick_slow : tick_fast;

    // 9-bit prescaler, cleared while disabled
    wire [WIT_PRE_WIDTH-1:0] pre_count;
    wire pre_clr = ~op_en;
    wire pre_inc = op_en & watch_tick;
    wit_counter #(.WIDTH(WIT_PRE_WIDTH)) u_pre (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(pre_clr),
        .inc(pre_inc),
        .count(pre_count)
    );

    // interval tap: low 4+code bits all ones on a tick ends one interval
    wire ivl_code_ok = (ivl_code <= WIT_IVL_MAX_CODE);
    wire [2:0] tap_shift = 3'(WIT_IVL_MAX_CODE - ivl_code);
    wire [WIT_PRE_WIDTH-1:0] tap_mask = {WIT_PRE_WIDTH{1'b1}} >> tap_shift;
    wire tap_full = &(pre_count | ~tap_mask);
    // prohibited codes raise no interval events at all
    wire ivl_event = pre_inc & ivl_code_ok & tap_full;

    // 5-bit watch counter; clearing only the run bit restarts it, prescaler runs on
    wire watch_run = op_en & run_ctl;
    wire pre_wrap = &pre_count;
    wire [WIT_CNT_WIDTH-1:0] cnt_count;
    wire cnt_clr = ~watch_run;
    // normal: one step per prescaler wrap (2^14 total); fast: one per tick (2^5)
    wire cnt_inc = watch_run & pre_inc & (fast_mode | pre_wrap);
    wit_counter #(.WIDTH(WIT_CNT_WIDTH)) u_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(cnt_clr),
        .inc(cnt_inc),
        .count(cnt_count)
    );
    wire watch_event = cnt_inc & (&cnt_count);

    // write channel decode
    wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire wr_mode = (awaddr_reg == ADDR_WIDTH'(WIT_MODE_ADDR));
    wire wr_status = (awaddr_reg == ADDR_WIDTH'(WIT_STATUS_ADDR));
    wire wr_mask = (awaddr_reg == ADDR_WIDTH'(WIT_MASK_ADDR));
    wire wr_hit = wr_mode | wr_status | wr_mask;
    // only byte lane 0 carries register data; strobes with lane 0 low leave it alone
    wire wr_lane0 = wr_fire & wstrb_reg[0];

    // register next values
    wire [7:0] mode_next = (wr_lane0 & wr_mode) ?
        (wdata_reg[7:0] & WIT_MODE_WMASK) : watch_mode_reg;
    wire [1:0] evt_now = {ivl_event, watch_event};
    wire [1:0] status_clr = (wr_lane0 & wr_status) ? wdata_reg[1:0] : 2'h0;
    // a new event wins over a simultaneous write-one clear
    wire [1:0] status_next = (status_reg & ~status_clr) | evt_now;
    wire [1:0] mask_next = (wr_lane0 & wr_mask) ? wdata_reg[1:0] : mask_reg;
    wire irq_next = |(status_next & mask_next);

    // read decode
    wire rd_fire = s_axi_arvalid & arready_reg;
    wire rd_mode = (s_axi_araddr == ADDR_WIDTH'(WIT_MODE_ADDR));
    wire rd_status = (s_axi_araddr == ADDR_WIDTH'(WIT_STATUS_ADDR));
    wire rd_mask = (s_axi_araddr == ADDR_WIDTH'(WIT_MASK_ADDR));
    wire rd_hit = rd_mode | rd_status | rd_mask;
    wire [31:0] rd_data = rd_mode ? {24'h00_0000, watch_mode_reg} :
        rd_status ? {30'h0000_0000, status_reg} :
        rd_mask ? {30'h0000_0000, mask_reg} : 32'h0000_0000;

    // mode, status, mask and interrupt registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watch_mode_reg <= WIT_MODE_RESET;
            status_reg <= WIT_EVT_RESET;
            mask_reg <= WIT_EVT_RESET;
            irq_reg <= 1'b0;
            watch_pulse_reg <= 1'b0;
            ivl_pulse_reg <= 1'b0;
        end else begin
            watch_mode_reg <= mode_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            watch_pulse_reg <= watch_event;
            ivl_pulse_reg <= ivl_event;
        end
    end

    // write address and data are caught independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid & ~aw_held_reg) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid & ~w_held_reg) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= WIT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? WIT_RESP_OKAY : WIT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read channel: one read at a time, arready drops while data waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= WIT_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (rd_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_hit ? WIT_RESP_OKAY : WIT_RESP_SLVERR;
            rdata_reg <= rd_data;
        end else if (rvalid_reg) begin
            rvalid_reg <= ~s_axi_rready;
            arready_reg <= s_axi_rready;
        end else begin
            arready_reg <= 1'b1;
        end
    end

    // outputs from flip-flops; awready and wready are the held flags inverted
    assign s_axi_awready = ~aw_held_reg;
    assign s_axi_wready = ~w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign irq = irq_reg;
    assign watch_interrupt_request = watch_pulse_reg;
    assign interval_interrupt_request = ivl_pulse_reg;
endmodule

// [hdl/wit_pkg.sv]
// package of constants for the watch interval timer block
package wit_pkg;
    // register indexes and byte addresses (byte address is four times the index)
    localparam logic [19:0] WIT_MODE_IDX = 20'h0_ff41;
    localparam logic [19:0] WIT_STATUS_IDX = 20'h0_ff50;
    localparam logic [19:0] WIT_MASK_IDX = 20'h0_ff51;
    localparam logic [21:0] WIT_MODE_ADDR = {WIT_MODE_IDX, 2'b00};
    localparam logic [21:0] WIT_STATUS_ADDR = {WIT_STATUS_IDX, 2'b00};
    localparam logic [21:0] WIT_MASK_ADDR = {WIT_MASK_IDX, 2'b00};
    // reset values
    localparam logic [7:0] WIT_MODE_RESET = 8'h00;
    localparam logic [1:0] WIT_EVT_RESET = 2'h0;
    // mode register field positions
    localparam int WIT_CLK_SEL_BIT = 7;
    localparam int WIT_IVL_LSB = 4;
    localparam int WIT_FAST_BIT = 3;
    localparam int WIT_RSVD_BIT = 2;
    localparam int WIT_RUN_BIT = 1;
    localparam int WIT_EN_BIT = 0;
    // writable bits of the mode register: bit 2 is held at zero
    localparam logic [7:0] WIT_MODE_WMASK = 8'hfb;
    // event bits in status and mask
    localparam int WIT_EVT_WATCH = 0;
    localparam int WIT_EVT_IVL = 1;
    // divider and counter sizes
    localparam int WIT_DIV_FAST_EXP = 7;
    localparam int WIT_DIV_SLOW_EXP = 11;
    localparam int WIT_PRE_WIDTH = 9;
    localparam int WIT_CNT_WIDTH = 5;
    localparam logic [2:0] WIT_IVL_MAX_CODE = 3'h5;
    // axi responses
    localparam logic [1:0] WIT_RESP_OKAY = 2'h0;
    localparam logic [1:0] WIT_RESP_SLVERR = 2'h2;
    // clock period in ns
    localparam int WIT_CLK_PERIOD_NS = 8;
endpackage

// [hdl/wit_counter.sv]
// clearable up-counter used for the clock divider, prescaler and watch counter
`timescale 1ns/1ps
module wit_counter
    import wit_pkg::*;
#(
    parameter int WIDTH = 9
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic clr,
    input wire logic inc,
    // state
    output logic [WIDTH-1:0] count
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // clear wins over increment, wraps at full scale
    assign count_next = clr ? '0 : (inc ? WIDTH'(count_reg + 1'b1) : count_reg);
    assign count = count_reg;

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// [verif/wit_top_properties.sv]
// concurrent checks on the watch interval timer ports
`timescale 1ns/1ps
module wit_top_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // events
    input wire logic irq,
    input wire logic watch_interrupt_request,
    input wire logic interval_interrupt_request
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // anything that raises the interrupt line at the same edge it shows up
    wire logic cause = watch_interrupt_request || interval_interrupt_request || s_axi_bvalid;
    // handshakes that launch a response
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    b_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");
    r_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not returned");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not retired");
    aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address accepted while one is held");
    // pulses are one cycle and ticks are at least 128 cycles apart
    watch_pulse_a: assert property (
        watch_interrupt_request |=> !watch_interrupt_request [*8])
        else $error("watch pulse too long");
    ivl_pulse_a: assert property (
        interval_interrupt_request |=> !interval_interrupt_request [*8])
        else $error("interval pulse too long");
    irq_cause_a: assert property (
        $rose(irq) |-> cause || $past(cause))
        else $error("interrupt raised without cause");
    reset_a: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && s_axi_awready)
        else $error("outputs not cleared by reset");
endmodule

bind wit_top wit_top_properties u_props (.*);

// [verif/test_watch_interval_timer.sv]
// self-checking bench for the watch interval timer
`timescale 1ns/1ps
module test_watch_interval_timer
    import wit_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, watch_interrupt_request, interval_interrupt_request;
    logic [21:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int n_fail, total_checks, n;

    wit_top dut (.*);

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one edge of a bounded bus wait; a hung slave ends the run
    task automatic edge_guard(inout int i);
        @(posedge aclk);
        i++;
        if (i > 100) begin
            n_fail++;
            final_report();
        end
    endtask

    // ready values are read just after the edge, i.e. as sampled there
    task automatic axi_wr(input logic [21:0] a, input logic [31:0] d);
        int i;
        i = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            edge_guard(i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
    endtask

    task automatic axi_rd(input logic [21:0] a);
        int i;
        i = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            edge_guard(i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    // cycles to the next pulse; lim + 1 means none came
    task automatic wait_pulse(input logic sel, input int lim, input logic must);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!(sel ? interval_interrupt_request : watch_interrupt_request) && n <= lim);
        if (must && n > lim) begin
            n_fail++;
            final_report();
        end
    endtask

    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // main sequence; response ready lines stay high throughout
    initial begin
        aresetn = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        s_axi_awaddr = 22'h0;
        s_axi_araddr = 22'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        n_fail = 0;
        total_checks = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(WIT_MODE_ADDR);
        check(rd, 32'h0000_0000);
        axi_wr(WIT_MODE_ADDR, 32'h0000_00df);
        axi_rd(WIT_MODE_ADDR);
        check(rd, 32'h0000_00db);
        axi_rd(22'h0);
        check({rd[29:0], resp}, 32'(WIT_RESP_SLVERR));
        axi_wr(22'h0, 32'h0000_00ff);
        check(32'(resp), 32'(WIT_RESP_SLVERR));
        // fast feed: one watch flag per 32 ticks of 128 cycles
        axi_wr(WIT_MODE_ADDR, 32'h0000_000b);
        wait_pulse(1'b0, 5000, 1'b1);
        wait_pulse(1'b0, 5000, 1'b1);
        check(32'(n), 32'h0000_1000);
        axi_rd(WIT_STATUS_ADDR);
        check({rd[31:1], irq}, 32'h0000_0002);
        // zero-second restart: counter stops, prescaler keeps running
        axi_wr(WIT_MODE_ADDR, 32'h0000_0009);
        wait_pulse(1'b1, 3000, 1'b1);
        wait_pulse(1'b1, 3000, 1'b1);
        check(32'(n), 32'h0000_0800);
        wait_pulse(1'b0, 4200, 1'b0);
        check(32'(n), 32'h0000_1069);
        axi_wr(WIT_MASK_ADDR, 32'h0000_0003);
        axi_rd(WIT_MASK_ADDR);
        check({rd[31:1], irq}, 32'h0000_0003);
        // stop, clear events, interrupt falls and nothing more arrives
        axi_wr(WIT_MODE_ADDR, 32'h0000_0000);
        axi_wr(WIT_STATUS_ADDR, 32'h0000_0003);
        axi_rd(WIT_STATUS_ADDR);
        check({rd[31:1], irq}, 32'h0000_0000);
        wait_pulse(1'b1, 2200, 1'b0);
        check(32'(n), 32'h0000_0899);
        // every legal interval code; the longest two are only read back
        for (int c = 0; c < 6; c++) begin
            axi_wr(WIT_MODE_ADDR, {25'h0, 3'(c), 4'h1});
            axi_rd(WIT_MODE_ADDR);
            check(rd, {25'h0, 3'(c), 4'h1});
            if (c < 4) begin
                wait_pulse(1'b1, 40000, 1'b1);
                wait_pulse(1'b1, 40000, 1'b1);
                check(32'(n), 32'(2048 << c));
            end
        end
        final_report();
    end
endmodule
